/* File: src/dts_edge_select.sv */
// Dead-time edge select block: APB registers, two dead-time units and
// per-channel, per-edge routing of the dead-time delay.
// Assumes edge events are one-cycle pulses synchronous to CORE_CLK.
//
// Notes on behaviour
// - Channel 3 inactive edge uses unit picked by bit 4.
// - Channel 2 active edge uses unit picked by bit 3.
// - Channel 2 inactive edge uses unit picked by bit 2.
// - Select one means unit B, zero means unit A.
// - Prescale 11 gives eight cycles, 10 gives four per count.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module dts_edge_select
  import dts_pkg::*;
(
  // Clock and reset
  input  wire logic                    CORE_CLK,
  input  wire logic                    RST,
  // APB slave
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [dts_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [dts_pkg::DATA_W-1:0] PWDATA,
  output logic      [dts_pkg::DATA_W-1:0] PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  // Edge events per channel
  input  wire logic [dts_pkg::NCH-1:0] ACT_EDGE,
  input  wire logic [dts_pkg::NCH-1:0] INACT_EDGE,
  // Dead-time status
  output logic      [dts_pkg::NCH-1:0] DEAD_BUSY,
  output logic      [dts_pkg::NCH-1:0] DEAD_UNIT,
  output logic                         UNIT_A_BUSY,
  output logic                         UNIT_B_BUSY,
  // Fault A control fields
  output logic      [5:0]              FAULT_OVERRIDE,
  output logic                         FAULT_A_MODE,
  output logic      [dts_pkg::NCH-1:0] FAULT_A_PAIR_EN
);
  import dts_pkg::*;

  logic [REG_W-1:0] dt_cfg_q;
  logic [REG_W-1:0] edge_sel_q;
  logic [REG_W-1:0] fault_a_q;
  logic             wr_en;
  logic             rd_en;
  logic             addr_ok;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] rdata;
  logic             start_a;
  logic             start_b;
  logic             busy_a;
  logic             busy_b;
  logic [NCH-1:0]   act_sel;
  logic [NCH-1:0]   ina_sel;
  logic [NCH-1:0]   unit_d;
  logic [NCH-1:0]   unit_q;
  logic [NCH-1:0]   pend_q;

  function automatic logic map_hit(input logic [ADDR_W-1:0] a);
    map_hit = (a == OFF_DT_CFG) || (a == OFF_EDGE_SEL)
           || (a == OFF_FAULT_A);
  endfunction : map_hit

  // Zero-wait slave; unmapped addresses answer with an error
  assign addr_ok = map_hit(PADDR);
  assign wr_en   = PSEL && PENABLE && PWRITE && addr_ok;
  assign rd_en   = PSEL && !PENABLE && !PWRITE;
  assign wdata   = PWDATA[REG_W-1:0];
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dt_cfg_q <= DT_CFG_RST;
    end else if (wr_en && PADDR == OFF_DT_CFG) begin
      dt_cfg_q <= wdata;
    end
  end

  // Only low six select bits stored
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      edge_sel_q <= EDGE_SEL_RST;
    end else if (wr_en && PADDR == OFF_EDGE_SEL) begin
      edge_sel_q <= wdata & EDGE_SEL_MASK;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      fault_a_q <= FAULT_A_RST;
    end else if (wr_en && PADDR == OFF_FAULT_A) begin
      fault_a_q <= wdata & FAULT_A_MASK;
    end
  end

  always_comb begin
    unique case (PADDR)
      OFF_DT_CFG:   rdata = dt_cfg_q;
      OFF_EDGE_SEL: rdata = edge_sel_q;
      OFF_FAULT_A:  rdata = fault_a_q;
      default:      rdata = '0;
    endcase
  end

  // Read data registered in setup so it is stable in the access phase
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PRDATA <= '0;
    end else if (rd_en) begin
      PRDATA <= {{(DATA_W-REG_W){1'b0}}, rdata};
    end
  end

  assign act_sel = {edge_sel_q[SEL_CH3_ACT], edge_sel_q[SEL_CH2_ACT],
                    edge_sel_q[SEL_CH1_ACT]};
  assign ina_sel = {edge_sel_q[SEL_CH3_INA], edge_sel_q[SEL_CH2_INA],
                    edge_sel_q[SEL_CH1_INA]};

  // Unit chosen for each channel's current edge; active edge wins a tie
  always_comb begin
    unit_d = unit_q;
    for (int i = 0; i < NCH; i++) begin
      if (ACT_EDGE[i]) begin
        unit_d[i] = act_sel[i];
      end else if (INACT_EDGE[i]) begin
        unit_d[i] = ina_sel[i];
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      unit_q <= '0;
    end else begin
      unit_q <= unit_d;
    end
  end

  // One routes to unit B, zero to unit A
  always_comb begin
    start_a = 1'b0;
    start_b = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (ACT_EDGE[i] || INACT_EDGE[i]) begin
        if (unit_d[i] == UNIT_B) begin
          start_b = 1'b1;
        end else begin
          start_a = 1'b1;
        end
      end
    end
  end

  // Channel stays in dead time while its unit counts
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pend_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        pend_q[i] <= ACT_EDGE[i] || INACT_EDGE[i];
      end
    end
  end

  // Units are shared; a new edge restarts the chosen unit
  dts_dead_timer u_unit_a (
    .clk      (CORE_CLK),
    .rst      (RST),
    .prescale (dt_cfg_q[DTA_PS_LSB +: PS_W]),
    .count    (dt_cfg_q[DTA_CNT_LSB +: CNT_W]),
    .start    (start_a),
    .busy     (busy_a)
  );

  dts_dead_timer u_unit_b (
    .clk      (CORE_CLK),
    .rst      (RST),
    .prescale (dt_cfg_q[DTB_PS_LSB +: PS_W]),
    .count    (dt_cfg_q[DTB_CNT_LSB +: CNT_W]),
    .start    (start_b),
    .busy     (busy_b)
  );

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      DEAD_BUSY <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        DEAD_BUSY[i] <= pend_q[i] ? 1'b1
                      : (DEAD_BUSY[i] &&
                         ((unit_q[i] == UNIT_B) ? busy_b : busy_a));
      end
    end
  end

  assign DEAD_UNIT       = unit_q;
  assign UNIT_A_BUSY     = busy_a;
  assign UNIT_B_BUSY     = busy_b;
  assign FAULT_OVERRIDE  = fault_a_q[13:8];
  assign FAULT_A_MODE    = fault_a_q[7];
  assign FAULT_A_PAIR_EN = fault_a_q[NCH-1:0];
endmodule : dts_edge_select
`default_nettype wire

/* File: src/dts_pkg.sv */
// Package for the dead-time edge select block: register map, field layout,
// reset values and prescale codes.
// Assumes a 32-bit APB slave with word-aligned 16-bit registers.
package dts_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned NCH    = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_DT_CFG   = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_EDGE_SEL = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_FAULT_A  = 4'h8;

  // Dead-time configuration: unit B prescale/count, unit A prescale/count
  localparam int unsigned DTB_PS_LSB  = 14;
  localparam int unsigned DTB_CNT_LSB = 8;
  localparam int unsigned DTA_PS_LSB  = 6;
  localparam int unsigned DTA_CNT_LSB = 0;
  localparam int unsigned PS_W        = 2;
  localparam int unsigned CNT_W       = 6;

  // Edge select bit positions
  localparam int unsigned SEL_CH3_ACT = 5;
  localparam int unsigned SEL_CH3_INA = 4;
  localparam int unsigned SEL_CH2_ACT = 3;
  localparam int unsigned SEL_CH2_INA = 2;
  localparam int unsigned SEL_CH1_ACT = 1;
  localparam int unsigned SEL_CH1_INA = 0;

  // Writable masks and reset values
  localparam logic [REG_W-1:0] EDGE_SEL_MASK  = 16'h003F;
  localparam logic [REG_W-1:0] EDGE_SEL_RST   = 16'h0000;
  localparam logic [REG_W-1:0] FAULT_A_MASK   = 16'h3F87;
  localparam logic [REG_W-1:0] FAULT_A_RST    = 16'h0007;
  localparam logic [REG_W-1:0] DT_CFG_RST     = 16'h0000;

  // Prescale codes to dead-time clock period in instruction cycles
  localparam logic [PS_W-1:0] PS_DIV1 = 2'h0;
  localparam logic [PS_W-1:0] PS_DIV2 = 2'h1;
  localparam logic [PS_W-1:0] PS_DIV4 = 2'h2;
  localparam logic [PS_W-1:0] PS_DIV8 = 2'h3;
  localparam int unsigned DIV_W = 3;

  // Unit select encoding
  localparam logic UNIT_A = 1'b0;
  localparam logic UNIT_B = 1'b1;
endpackage : dts_pkg

/* File: src/dts_dead_timer.sv */
// One dead-time unit: prescaled down-counter started by an edge event.
// Assumes the caller holds prescale and count stable while running.
`timescale 1ns/10ps
`default_nettype none
module dts_dead_timer
  import dts_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Setup
  input  wire logic [dts_pkg::PS_W-1:0]  prescale,
  input  wire logic [dts_pkg::CNT_W-1:0] count,
  // Control
  input  wire logic                      start,
  output logic                           busy
);
  import dts_pkg::*;

  logic [DIV_W-1:0] div_q;
  logic [CNT_W-1:0] cnt_q;
  logic             tick;

  function automatic logic [DIV_W-1:0] ps_limit(input logic [PS_W-1:0] ps);
    unique case (ps)
      PS_DIV1: ps_limit = 3'h0;
      PS_DIV2: ps_limit = 3'h1;
      PS_DIV4: ps_limit = 3'h3;
      PS_DIV8: ps_limit = 3'h7;
    endcase
  endfunction : ps_limit

  assign tick = (div_q == ps_limit(prescale));

  always_ff @(posedge clk) begin
    if (rst || start || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= count;
    end else if (tick && cnt_q != '0) begin
      cnt_q <= cnt_q - 6'h01;
    end
  end

  assign busy = (cnt_q != '0);
endmodule : dts_dead_timer
`default_nettype wire

/* File: dv/dts_edge_select_properties.sv */
// Checker for dts_edge_select: edge to unit routing at the ports.
// Assumes bind to the top; shadows the select register from APB writes.
`timescale 1ns/10ps
`default_nettype none
module dts_chk
  import dts_pkg::*;
(
  // Clock, reset, APB
  input wire logic                       CORE_CLK,
  input wire logic                       RST,
  input wire logic                       PSEL,
  input wire logic                       PENABLE,
  input wire logic                       PWRITE,
  input wire logic [dts_pkg::ADDR_W-1:0] PADDR,
  input wire logic [dts_pkg::DATA_W-1:0] PWDATA,
  input wire logic                       PSLVERR,
  // Edges and routing
  input wire logic [dts_pkg::NCH-1:0]    ACT_EDGE,
  input wire logic [dts_pkg::NCH-1:0]    INACT_EDGE,
  input wire logic [dts_pkg::NCH-1:0]    DEAD_UNIT
);
  logic [5:0] sel_q;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sel_q <= 6'h00;
    end else if (PSEL && PENABLE && PWRITE && PADDR == OFF_EDGE_SEL) begin
      sel_q <= PWDATA[5:0];
    end
  end
  chk_ch3_act_unit: assert property (
    ACT_EDGE[2] |=> DEAD_UNIT[2] == $past(sel_q[5]))
    else $error("ch3 active edge took wrong unit");
  chk_ch3_inact_unit: assert property (
    INACT_EDGE[2] && !ACT_EDGE[2] ##1 1'b1 |-> DEAD_UNIT[2] == $past(sel_q[4]))
    else $error("ch3 inactive edge took wrong unit");
  chk_ch2_act_unit: assert property (
    ACT_EDGE[1] |=> DEAD_UNIT[1] == $past(sel_q[3]))
    else $error("ch2 active edge took wrong unit");
  chk_ch2_inact_unit: assert property (
    INACT_EDGE[1] && !ACT_EDGE[1] |=> DEAD_UNIT[1] == $past(sel_q[2]))
    else $error("ch2 inactive edge took wrong unit");
  chk_ch1_act_unit: assert property (
    ACT_EDGE[0] |=> DEAD_UNIT[0] == $past(sel_q[1]))
    else $error("ch1 active edge took wrong unit");
  chk_ch1_inact_unit: assert property (
    INACT_EDGE[0] && !ACT_EDGE[0] |=> DEAD_UNIT[0] == $past(sel_q[0]))
    else $error("ch1 inactive edge took wrong unit");
  // Any address outside the three registers flags an error
  chk_unmapped_err: assert property (
    PSEL && PENABLE |-> PSLVERR == !(PADDR == OFF_DT_CFG
      || PADDR == OFF_EDGE_SEL || PADDR == OFF_FAULT_A))
    else $error("slave error flag wrong for address");
endmodule : dts_chk
`default_nettype wire

/* File: dv/tb.sv */
// Testbench for dts_edge_select: registers over APB, routing, dead time.
// Assumes a zero-wait APB slave and one-cycle edge pulses.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dts_pkg::*;
  logic              CORE_CLK = 1'b0;
  logic              RST = 1'b1;
  logic              PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = 4'h0;
  logic [DATA_W-1:0] PWDATA = 32'h0, PRDATA, rd;
  logic              PREADY, PSLVERR, UNIT_A_BUSY, UNIT_B_BUSY, FAULT_A_MODE;
  logic [NCH-1:0]    ACT_EDGE = 3'h0, INACT_EDGE = 3'h0;
  logic [NCH-1:0]    DEAD_BUSY, DEAD_UNIT, FAULT_A_PAIR_EN;
  logic [5:0]        FAULT_OVERRIDE, sel;
  logic              perr;
  int                n_mismatch = 0, n_compared = 0;
  always #25 CORE_CLK = ~CORE_CLK;
  dts_edge_select dut (.CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .ACT_EDGE, .INACT_EDGE, .DEAD_BUSY,
    .DEAD_UNIT, .UNIT_A_BUSY, .UNIT_B_BUSY, .FAULT_OVERRIDE, .FAULT_A_MODE,
    .FAULT_A_PAIR_EN);
  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic cmp_word(input logic [DATA_W-1:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, exp);
    cmp_word(32'(got), 32'(exp));
  endtask : cmp_bit
  // Unit A: 3 counts of 4 cycles; unit B: 2 counts of 8 cycles
  function automatic int exp_len(input logic u);
    return u ? 2 * 8 : 3 * 4;
  endfunction : exp_len
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    int i;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge CORE_CLK);
      if (PREADY === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      end_of_test();
    end
    rd = PRDATA;
    perr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic edge_chk(input int ch, input logic act);
    int n;
    logic u;
    u = sel[ch * 2 + int'(act)];
    n = 0;
    @(posedge CORE_CLK);
    if (act) ACT_EDGE <= 3'(1 << ch);
    else INACT_EDGE <= 3'(1 << ch);
    @(posedge CORE_CLK);
    ACT_EDGE <= 3'h0;
    INACT_EDGE <= 3'h0;
    #1;
    cmp_bit(DEAD_UNIT[ch], u);
    cmp_bit(u ? UNIT_B_BUSY : UNIT_A_BUSY, 1'b1);
    for (int i = 0; i < 300 && n == i; i++) begin
      @(posedge CORE_CLK);
      #1;
      if (DEAD_BUSY[ch] === 1'b1) n++;
    end
    cmp_word(32'(n), 32'(exp_len(u)));
  endtask : edge_chk
  logic [ADDR_W-1:0] offs [3] = '{4'h4, 4'h8, 4'hC};
  logic [DATA_W-1:0] rexp [3] = '{32'h0, 32'h7, 32'h0};
  logic [DATA_W-1:0] wexp [3] = '{32'h3F, 32'h3F87, 32'h0};
  initial begin
    void'($urandom(30));
    repeat (4) @(posedge CORE_CLK);
    RST <= 1'b0;
    // Reset values first, then all-ones writes and read back
    for (int k = 0; k < 2; k++) begin
      foreach (offs[j]) begin
        if (k == 1) apb(1'b1, offs[j], 32'hFFFF_FFFF);
        apb(1'b0, offs[j], 32'h0);
        cmp_word(rd, k == 1 ? wexp[j] : rexp[j]);
        cmp_bit(perr, j == 2);
      end
    end
    cmp_word(32'({FAULT_OVERRIDE, FAULT_A_MODE, FAULT_A_PAIR_EN}), 32'h3FF);
    $display("test registers done");
    apb(1'b1, OFF_DT_CFG, 32'h0000_C283);
    apb(1'b0, OFF_DT_CFG, 32'h0);
    cmp_word(rd, 32'h0000_C283);
    for (int t = 0; t < 10; t++) begin
      sel = t == 0 ? 6'h00 : t == 1 ? 6'h3F : 6'($urandom);
      apb(1'b1, OFF_EDGE_SEL, 32'(sel));
      for (int ch = 0; ch < 3; ch++) begin
        edge_chk(ch, 1'b1);
        edge_chk(ch, 1'b0);
      end
    end
    $display("test routing done");
    end_of_test();
  end
endmodule : tb
bind dts_edge_select dts_chk chk (.CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PSLVERR, .ACT_EDGE, .INACT_EDGE, .DEAD_UNIT);
`default_nettype wire
